// ==== hsac_top.sv ====
// Hop sync mode control, sniff window, sync loss and channel access
// Assumes hop ticks, link events and role straps come from the modem core
//
// What this block does
// - Master sync mode setting picks normal, quick-until-ack or quick-until-timeout
// - Quick sync drives the fast hop rate output
// - Mode 1 only in point-to-point; quick until Slave acknowledges
// - After ack, stay fast for hold hops, then normal
// - Mode 2 goes quick on online, normal after fast timeout
// - Fast timeout in ms, Master mode 2 only, 100 to 65000, default 200
// - Remote sniffs for configured hops after sleep expiry, 1..255, default 10
// - Sniff duration is hop count times hop interval
// - With channel request on, Remote asks; grant is exclusive until release
// - In TDMA, Master refuses requests and polls Remotes in turn
// - Slave missing sync for configured hops goes unsynced and searches
// - Sniffing Remote finding no Master returns to sleep
`timescale 1ns/1ps
`default_nettype none
module hsac_top #(
    parameter int N_REMOTES = 4,
    parameter int CYC_PER_MS = hsac_pkg::CYC_PER_MS
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire hsac_pkg::hsac_cfg_wr_s cfg_wr_i,
    output logic [15:0] cfg_rd_data_o,
    input wire logic [2:0] cfg_rd_idx_i,
    input wire logic is_master_i,
    input wire logic ptp_topology_i,
    input wire logic tdma_mode_i,
    input wire logic online_i,
    input wire logic hop_tick_i,
    input wire logic ack_rx_i,
    input wire logic sync_rx_i,
    input wire logic sleep_expired_i,
    input wire logic master_found_i,
    input wire logic [N_REMOTES-1:0] chan_req_i,
    input wire logic [N_REMOTES-1:0] chan_release_i,
    output logic fast_hop_o,
    output logic sniffing_o,
    output logic go_sleep_o,
    output logic synced_o,
    output logic searching_o,
    output logic [N_REMOTES-1:0] chan_grant_o,
    output logic [N_REMOTES-1:0] tdma_slot_o
);
    localparam int IW = $clog2(N_REMOTES) > 0 ? $clog2(N_REMOTES) : 1;
    default clocking @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    logic [7:0] sync_mode_reg;
    logic [15:0] fast_to_reg;
    logic [7:0] hold_reg;
    logic [7:0] sniff_reg;
    logic [7:0] chreq_reg;
    logic [15:0] loss_reg;

    wire logic [15:0] wd = cfg_wr_i.data;
    wire logic wr_sync = cfg_wr_i.we && cfg_wr_i.idx == hsac_pkg::IDX_SYNC_MODE
        && wd <= 16'(hsac_pkg::SYNC_MODE_MAX);
    wire logic wr_fast = cfg_wr_i.we && cfg_wr_i.idx == hsac_pkg::IDX_FAST_TO
        && wd >= hsac_pkg::FAST_TO_MIN && wd <= hsac_pkg::FAST_TO_MAX;
    wire logic wr_hold = cfg_wr_i.we && cfg_wr_i.idx == hsac_pkg::IDX_HOLD
        && wd >= 16'(hsac_pkg::HOLD_MIN) && wd <= 16'h00ff;
    wire logic wr_sniff = cfg_wr_i.we && cfg_wr_i.idx == hsac_pkg::IDX_SNIFF
        && wd >= 16'(hsac_pkg::SNIFF_MIN) && wd <= 16'h00ff;
    wire logic wr_chreq = cfg_wr_i.we && cfg_wr_i.idx == hsac_pkg::IDX_CHREQ
        && wd <= 16'h0001;
    wire logic wr_loss = cfg_wr_i.we && cfg_wr_i.idx == hsac_pkg::IDX_LOSS
        && wd >= hsac_pkg::LOSS_MIN && wd <= hsac_pkg::LOSS_MAX;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            sync_mode_reg <= hsac_pkg::SYNC_MODE_RST;
            fast_to_reg <= hsac_pkg::FAST_TO_RST;
            hold_reg <= hsac_pkg::HOLD_RST;
            sniff_reg <= hsac_pkg::SNIFF_RST;
            chreq_reg <= hsac_pkg::CHREQ_RST;
            loss_reg <= hsac_pkg::LOSS_RST;
        end else begin
            if (wr_sync) sync_mode_reg <= wd[7:0];
            if (wr_fast) fast_to_reg <= wd;
            if (wr_hold) hold_reg <= wd[7:0];
            if (wr_sniff) sniff_reg <= wd[7:0];
            if (wr_chreq) chreq_reg <= wd[7:0];
            if (wr_loss) loss_reg <= wd;
        end
    end

    // Reads are combinational; data lines follow registers directly
    always_comb begin
        unique case (cfg_rd_idx_i)
            hsac_pkg::IDX_SYNC_MODE: cfg_rd_data_o = {8'h00, sync_mode_reg};
            hsac_pkg::IDX_FAST_TO: cfg_rd_data_o = fast_to_reg;
            hsac_pkg::IDX_HOLD: cfg_rd_data_o = {8'h00, hold_reg};
            hsac_pkg::IDX_SNIFF: cfg_rd_data_o = {8'h00, sniff_reg};
            hsac_pkg::IDX_CHREQ: cfg_rd_data_o = {8'h00, chreq_reg};
            hsac_pkg::IDX_LOSS: cfg_rd_data_o = loss_reg;
            default: cfg_rd_data_o = {14'h0000, synced_o, fast_hop_o};
        endcase
    end

    // ------------------------------------------------------------
    // Master sync mode
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        HSAC_OFFLINE, HSAC_NORMAL, HSAC_QUICK_WAIT_ACK, HSAC_QUICK_HOLD, HSAC_QUICK_TIMED
    } hsac_ms_e;
    hsac_ms_e ms_reg, ms_next;
    logic online_d_reg;
    logic [7:0] hold_cnt_reg;
    wire logic online_rise = online_i && !online_d_reg;
    wire logic fast_done;
    wire logic hold_end = hop_tick_i && hold_cnt_reg == 8'h01;

    hsac_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_ms_timer (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .start_i(online_rise && is_master_i && sync_mode_reg == 8'h02),
        .ms_i(fast_to_reg),
        .done_o(fast_done)
    );

    always_comb begin
        ms_next = ms_reg;
        unique case (ms_reg)
            HSAC_OFFLINE: if (online_rise && is_master_i) begin
                if (sync_mode_reg == 8'h01 && ptp_topology_i) ms_next = HSAC_QUICK_WAIT_ACK;
                else if (sync_mode_reg == 8'h02) ms_next = HSAC_QUICK_TIMED;
                else ms_next = HSAC_NORMAL;
            end
            HSAC_QUICK_WAIT_ACK: if (ack_rx_i) ms_next = HSAC_QUICK_HOLD;
            HSAC_QUICK_HOLD: if (hold_end) ms_next = HSAC_NORMAL;
            HSAC_QUICK_TIMED: if (fast_done) ms_next = HSAC_NORMAL;
            HSAC_NORMAL: ms_next = HSAC_NORMAL;
            default: ms_next = HSAC_OFFLINE;
        endcase
        if (!online_i) ms_next = HSAC_OFFLINE;
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            ms_reg <= HSAC_OFFLINE;
            online_d_reg <= 1'b0;
            hold_cnt_reg <= 8'h00;
        end else begin
            ms_reg <= ms_next;
            online_d_reg <= online_i;
            if (ms_reg == HSAC_QUICK_WAIT_ACK && ack_rx_i) hold_cnt_reg <= hold_reg;
            else if (ms_reg == HSAC_QUICK_HOLD && hop_tick_i) hold_cnt_reg <= hold_cnt_reg - 8'h01;
        end
    end

    // Quick states all share one fast hop rate request to the hop engine
    assign fast_hop_o = ms_reg == HSAC_QUICK_WAIT_ACK || ms_reg == HSAC_QUICK_HOLD
        || ms_reg == HSAC_QUICK_TIMED;

    // ------------------------------------------------------------
    // Remote sniff window
    // ------------------------------------------------------------
    // Counting hops rather than time makes the window scale with hop interval
    wire logic sniff_exp;
    wire logic sniff_run;
    logic sleep_reg;
    hsac_hop_timer #(.W(8)) u_sniff (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .load_i(sleep_expired_i && !is_master_i),
        .count_i(sniff_reg),
        .hop_tick_i(hop_tick_i && !master_found_i),
        .expired_o(sniff_exp),
        .running_o(sniff_run)
    );
    assign sniffing_o = sniff_run && !master_found_i;
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) sleep_reg <= 1'b0;
        else sleep_reg <= sniff_exp && !master_found_i;
    end
    assign go_sleep_o = sleep_reg;

    // ------------------------------------------------------------
    // Slave sync loss
    // ------------------------------------------------------------
    wire logic loss_exp;
    logic synced_reg;
    hsac_hop_timer #(.W(16)) u_loss (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .load_i(sync_rx_i),
        .count_i(loss_reg),
        .hop_tick_i(hop_tick_i),
        .expired_o(loss_exp),
        .running_o()
    );
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) synced_reg <= 1'b0;
        else if (sync_rx_i) synced_reg <= 1'b1;
        else if (loss_exp) synced_reg <= 1'b0;
    end
    assign synced_o = is_master_i || synced_reg;
    assign searching_o = !is_master_i && !synced_reg;

    // ------------------------------------------------------------
    // Channel access
    // ------------------------------------------------------------
    logic [N_REMOTES-1:0] grant_reg;
    logic [IW-1:0] poll_reg;
    wire logic busy = |grant_reg;
    logic [N_REMOTES-1:0] pick;
    always_comb begin
        pick = '0;
        for (int i = N_REMOTES - 1; i >= 0; i--) begin
            if (chan_req_i[i]) pick = N_REMOTES'(1) << i;
        end
    end
    wire logic req_mode = chreq_reg[0] && !tdma_mode_i;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            grant_reg <= '0;
            poll_reg <= '0;
        end else if (!is_master_i || !req_mode) begin
            grant_reg <= '0;
            if (is_master_i && tdma_mode_i && hop_tick_i)
                poll_reg <= (poll_reg == IW'(N_REMOTES - 1)) ? '0 : poll_reg + IW'(1);
        end else if (busy) begin
            if (|(grant_reg & chan_release_i)) grant_reg <= '0;
        end else begin
            grant_reg <= pick;
        end
    end
    assign chan_grant_o = grant_reg;
    assign tdma_slot_o = (is_master_i && tdma_mode_i) ? N_REMOTES'(1) << poll_reg : '0;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_grant_onehot: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        $onehot0(grant_reg)) else $error("more than one grant");
    a_tdma_no_grant: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        tdma_mode_i |=> grant_reg == '0) else $error("grant in tdma");
    a_ack_hold: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        ms_reg == HSAC_QUICK_WAIT_ACK && ack_rx_i && online_i |=> ms_reg == HSAC_QUICK_HOLD)
        else $error("ack not taken");
    a_fast_rate: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        !online_i |=> !fast_hop_o) else $error("fast hop while offline");
    a_bad_wr: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        cfg_wr_i.we && cfg_wr_i.idx == hsac_pkg::IDX_SNIFF && wd == 16'h0000
        |=> $stable(sniff_reg)) else $error("bad sniff write");
    a_loss_unsync: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        loss_exp && !sync_rx_i |=> !synced_reg) else $error("sync loss ignored");
    a_mode2_enter: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        ms_reg == HSAC_OFFLINE && online_rise && is_master_i && sync_mode_reg == 8'h02
        |=> fast_hop_o) else $error("mode 2 not quick");
    a_sniff_sleep: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        sniff_exp && !master_found_i |=> go_sleep_o) else $error("no sleep");
    a_mode0_normal: assert property (
        ms_reg == HSAC_OFFLINE && online_rise && is_master_i && sync_mode_reg == 8'h00
        |=> ms_reg == HSAC_NORMAL) else $error("mode 0 not normal");
    a_mode1_ptp: assert property (
        ms_reg == HSAC_OFFLINE && online_rise && is_master_i && sync_mode_reg == 8'h01
        && ptp_topology_i |=> ms_reg == HSAC_QUICK_WAIT_ACK) else $error("mode 1 not quick");
    a_mode1_multi: assert property (
        ms_reg == HSAC_OFFLINE && online_rise && is_master_i && sync_mode_reg == 8'h01
        && !ptp_topology_i |=> ms_reg == HSAC_NORMAL) else $error("mode 1 quick off ptp");
    a_hold_load: assert property (
        ms_reg == HSAC_QUICK_WAIT_ACK && ack_rx_i |=> hold_cnt_reg == $past(hold_reg))
        else $error("hold count not loaded");
    a_hold_count: assert property (
        ms_reg == HSAC_QUICK_HOLD && online_i && hop_tick_i && hold_cnt_reg != 8'h01
        |=> ms_reg == HSAC_QUICK_HOLD && hold_cnt_reg == $past(hold_cnt_reg) - 8'h01)
        else $error("hold count not stepped");
    a_hold_end: assert property (
        ms_reg == HSAC_QUICK_HOLD && online_i && hold_end |=> ms_reg == HSAC_NORMAL)
        else $error("hold not ended");
    a_timed_end: assert property (
        ms_reg == HSAC_QUICK_TIMED && online_i && fast_done |=> !fast_hop_o)
        else $error("timed quick not ended");
    a_mode_keep: assert property (
        cfg_wr_i.we && cfg_wr_i.idx == hsac_pkg::IDX_SYNC_MODE && wd > 16'h0002
        |=> $stable(sync_mode_reg)) else $error("bad mode write taken");
    a_fast_keep: assert property (
        cfg_wr_i.we && cfg_wr_i.idx == hsac_pkg::IDX_FAST_TO
        && (wd < hsac_pkg::FAST_TO_MIN || wd > hsac_pkg::FAST_TO_MAX)
        |=> $stable(fast_to_reg)) else $error("bad timeout write taken");
    a_sniff_load: assert property (
        sleep_expired_i && !is_master_i |=> sniff_run)
        else $error("sniff not started");
    a_sync_set: assert property (
        sync_rx_i |=> synced_reg) else $error("sync not taken");
    a_grant_keep: assert property (
        busy && is_master_i && req_mode && !(|(grant_reg & chan_release_i))
        |=> grant_reg == $past(grant_reg)) else $error("grant dropped early");
    a_grant_free: assert property (
        |(grant_reg & chan_release_i) |=> grant_reg == '0) else $error("grant not freed");
    a_grant_lowest: assert property (
        !busy && is_master_i && req_mode |=> grant_reg == ($past(chan_req_i) & -$past(chan_req_i)))
        else $error("grant not lowest");
    a_slot_onehot: assert property (
        is_master_i && tdma_mode_i |-> $onehot(tdma_slot_o)) else $error("slot not one hot");
endmodule
`default_nettype wire

// ==== hsac_pkg.sv ====
// Package for hop sync and channel access logic
// Assumes a single 25 MHz clock domain and synchronous active-low reset
package hsac_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25000000;
    localparam int CYC_PER_MS = CLK_HZ / 1000;

    // ------------------------------------------------------------
    // Reset values and ranges
    // ------------------------------------------------------------
    localparam logic [7:0] SYNC_MODE_RST = 8'h00;
    localparam logic [7:0] SYNC_MODE_MAX = 8'h02;
    localparam logic [15:0] FAST_TO_RST = 16'h00c8;
    localparam logic [15:0] FAST_TO_MIN = 16'h0064;
    localparam logic [15:0] FAST_TO_MAX = 16'hfde8;
    localparam logic [7:0] SNIFF_RST = 8'h0a;
    localparam logic [7:0] SNIFF_MIN = 8'h01;
    localparam logic [7:0] HOLD_RST = 8'h08;
    localparam logic [7:0] HOLD_MIN = 8'h08;
    localparam logic [7:0] CHREQ_RST = 8'h01;
    localparam logic [15:0] LOSS_RST = 16'h0200;
    localparam logic [15:0] LOSS_MIN = 16'h0001;
    localparam logic [15:0] LOSS_MAX = 16'hfffe;

    // ------------------------------------------------------------
    // Configuration register indices
    // ------------------------------------------------------------
    localparam logic [2:0] IDX_SYNC_MODE = 3'h0;
    localparam logic [2:0] IDX_FAST_TO = 3'h1;
    localparam logic [2:0] IDX_HOLD = 3'h2;
    localparam logic [2:0] IDX_SNIFF = 3'h3;
    localparam logic [2:0] IDX_CHREQ = 3'h4;
    localparam logic [2:0] IDX_LOSS = 3'h5;

    typedef enum logic [1:0] {
        HSAC_SYNC_NORMAL,
        HSAC_SYNC_QUICK_ACK,
        HSAC_SYNC_QUICK_TIMEOUT
    } hsac_sync_e;

    typedef struct packed {
        logic we;
        logic [2:0] idx;
        logic [15:0] data;
    } hsac_cfg_wr_s;

endpackage

// ==== hsac_hop_timer.sv ====
// Down counter of hop ticks, used for sniff window and sync loss
// Assumes hop_tick_i is a one-cycle pulse per hop interval
`timescale 1ns/1ps
`default_nettype none
module hsac_hop_timer #(
    parameter int W = 16
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic load_i,
    input wire logic [W-1:0] count_i,
    input wire logic hop_tick_i,
    output logic expired_o,
    output logic running_o
);
    logic [W-1:0] cnt_reg;
    logic run_reg;
    logic exp_reg;
    wire logic last_hop = run_reg && hop_tick_i && (cnt_reg == W'(1));

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
            exp_reg <= 1'b0;
        end else begin
            exp_reg <= last_hop && !load_i;
            if (load_i) begin
                cnt_reg <= count_i;
                run_reg <= 1'b1;
            end else if (run_reg && hop_tick_i) begin
                cnt_reg <= cnt_reg - W'(1);
                run_reg <= !last_hop;
            end
        end
    end

    assign expired_o = exp_reg;
    assign running_o = run_reg;
endmodule
`default_nettype wire

// ==== hsac_ms_timer.sv ====
// Millisecond timer for the fast sync timeout
// Assumes a free-running core clock at the package rate
`timescale 1ns/1ps
`default_nettype none
module hsac_ms_timer #(
    parameter int CYC_PER_MS = hsac_pkg::CYC_PER_MS
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic start_i,
    input wire logic [15:0] ms_i,
    output logic done_o
);
    logic [15:0] ms_reg;
    logic [31:0] pre_reg;
    logic run_reg;
    logic done_reg;
    wire logic ms_tick = run_reg && (pre_reg == 32'(CYC_PER_MS - 1));

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            ms_reg <= '0;
            pre_reg <= '0;
            run_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (start_i) begin
                ms_reg <= ms_i;
                pre_reg <= '0;
                run_reg <= 1'b1;
            end else if (run_reg) begin
                pre_reg <= ms_tick ? '0 : pre_reg + 32'd1;
                if (ms_tick) begin
                    ms_reg <= ms_reg - 16'd1;
                    if (ms_reg == 16'd1) begin
                        run_reg <= 1'b0;
                        done_reg <= 1'b1;
                    end
                end
            end
        end
    end

    assign done_o = done_reg;
endmodule
`default_nettype wire

// ==== hsac_far_model.sv ====
// Far-side model: hop clock of the modem core and the associated Slave
// Assumes one clock; hop spacing is kept short so runs stay brief
`timescale 1ns/1ps
`default_nettype none
module hsac_far_model #(
    parameter int SLOW = 8,
    parameter int FAST = 4,
    parameter int ACK_HOPS = 5
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic fast_hop_i,
    input wire logic ack_en_i,
    input wire logic sync_en_i,
    output logic hop_tick_o,
    output logic ack_o,
    output logic sync_o
);
    logic [7:0] cnt_reg;
    logic [7:0] hops_reg;
    logic acked_reg;
    // Hops come quicker while the Master is in quick sync
    wire logic wrap = cnt_reg >= 8'(fast_hop_i ? FAST - 1 : SLOW - 1);
    wire logic ack_now = fast_hop_i && ack_en_i && wrap && !acked_reg
        && hops_reg == 8'(ACK_HOPS - 1);
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            cnt_reg <= '0;
            hops_reg <= '0;
            acked_reg <= 1'b0;
            hop_tick_o <= 1'b0;
            ack_o <= 1'b0;
            sync_o <= 1'b0;
        end else begin
            cnt_reg <= wrap ? 8'h00 : cnt_reg + 8'h01;
            hop_tick_o <= wrap;
            sync_o <= wrap && sync_en_i;
            ack_o <= ack_now;
            if (!fast_hop_i || !ack_en_i) begin
                hops_reg <= '0;
                acked_reg <= 1'b0;
            end else if (wrap && !acked_reg) begin
                hops_reg <= hops_reg + 8'h01;
                acked_reg <= ack_now;
            end
        end
    end
endmodule
`default_nettype wire

// ==== hsac_top_tb.sv ====
// Testbench for hsac_top with the far-side model
// Assumes a shortened millisecond count; master_found_i is raised in one sniff case
`timescale 1ns/1ps
`default_nettype none
module hsac_top_tb;
    localparam int CPM = 10;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    hsac_pkg::hsac_cfg_wr_s cfg = '0;
    logic [2:0] rd_idx = 3'h0;
    logic is_master = 1'b1, point_to_point_topology = 1'b0, tdma = 1'b0, online = 1'b0;
    logic sleep_exp = 1'b0, ack_en = 1'b0, sync_en = 1'b0, found = 1'b0;
    logic [3:0] req = 4'h0, rel = 4'h0;
    logic [15:0] rd_data, v, ex;
    logic hop_tick, ack, sync, fast, sniff, go_sleep, synced, searching;
    logic [3:0] grant, slot, s0;
    logic [31:0] seed = 32'h0000_bf9e;
    int error_cnt = 0, num_checks = 0, n, k;
    logic [15:0] tv [5] = '{16'h0063, 16'h0064, 16'hfde8, 16'hfde9, 16'h0000};

    hsac_top #(.N_REMOTES(4), .CYC_PER_MS(CPM)) u_dut (.core_clk_i(clk), .nrst_i(nrst),
        .cfg_wr_i(cfg), .cfg_rd_data_o(rd_data), .cfg_rd_idx_i(rd_idx),
        .is_master_i(is_master), .ptp_topology_i(point_to_point_topology), .tdma_mode_i(tdma),
        .online_i(online), .hop_tick_i(hop_tick), .ack_rx_i(ack), .sync_rx_i(sync),
        .sleep_expired_i(sleep_exp), .master_found_i(found), .chan_req_i(req),
        .chan_release_i(rel), .fast_hop_o(fast), .sniffing_o(sniff),
        .go_sleep_o(go_sleep), .synced_o(synced), .searching_o(searching),
        .chan_grant_o(grant), .tdma_slot_o(slot));
    hsac_far_model u_far (.core_clk_i(clk), .nrst_i(nrst), .fast_hop_i(fast),
        .ack_en_i(ack_en), .sync_en_i(sync_en), .hop_tick_o(hop_tick), .ack_o(ack),
        .sync_o(sync));

    initial begin
        forever #20 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] keep(input logic [15:0] o, input logic [15:0] w,
        input logic [15:0] lo, input logic [15:0] hi);
        return (w >= lo && w <= hi) ? w : o;
    endfunction
    function logic cond(input int w);
        return w == 0 ? fast : (w == 1 ? !go_sleep : synced);
    endfunction
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic near(input string name, input int m, input int e, input int tol);
        chk(name, 16'(m >= e && m <= e + tol), 16'h0001);
    endtask
    task automatic wr(input logic [2:0] idx, input logic [15:0] d);
        @(posedge clk);
        cfg <= '{we: 1'b1, idx: idx, data: d};
        @(posedge clk);
        cfg <= '0;
    endtask
    task automatic rd(input logic [2:0] idx, input logic [15:0] e, input string name);
        @(posedge clk);
        rd_idx <= idx;
        @(negedge clk);
        chk(name, rd_data, e);
    endtask
    // Counts cycles while the chosen condition holds; a stuck one ends the run
    task automatic len(input int w, output int m);
        m = 0;
        while (cond(w) === 1'b1 && m < 5000) begin
            @(negedge clk);
            m++;
        end
        if (m >= 5000) begin
            error_cnt++;
            wrap_up();
        end
    endtask
    task automatic go_online();
        @(posedge clk);
        online <= 1'b0;
        repeat (2) @(posedge clk);
        online <= 1'b1;
        repeat (2) @(negedge clk);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        error_cnt++;
        wrap_up();
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        rd(3'h0, 16'(hsac_pkg::SYNC_MODE_RST), "mode_rst");
        rd(3'h1, hsac_pkg::FAST_TO_RST, "timeout_rst");
        rd(3'h2, 16'(hsac_pkg::HOLD_RST), "hold_rst");
        rd(3'h3, 16'(hsac_pkg::SNIFF_RST), "sniff_rst");
        rd(3'h4, 16'(hsac_pkg::CHREQ_RST), "chreq_rst");
        rd(3'h5, hsac_pkg::LOSS_RST, "loss_rst");
        $display("reset values done");
        ex = hsac_pkg::FAST_TO_RST;
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            v = i < 5 ? tv[i] : seed[15:0];
            wr(3'h1, v);
            ex = keep(ex, v, 16'h0064, 16'hfde8);
            rd(3'h1, ex, "timeout_wr");
        end
        ex = 16'h0000;
        for (int i = 0; i < 5; i++) begin
            wr(3'h0, 16'(i));
            ex = keep(ex, 16'(i), 16'h0000, 16'h0002);
            rd(3'h0, ex, "mode_wr");
        end
        ex = 16'h000a;
        for (int i = 0; i < 4; i++) begin
            v = i == 0 ? 16'h0000 : (i == 1 ? 16'h00ff : (i == 2 ? 16'h0100 : 16'h0001));
            wr(3'h3, v);
            ex = keep(ex, v, 16'h0001, 16'h00ff);
            rd(3'h3, ex, "sniff_wr");
        end
        $display("config range done");
        wr(3'h0, 16'h0000);
        go_online();
        chk("fast_mode0", 16'(fast), 16'h0000);
        wr(3'h0, 16'h0001);
        go_online();
        chk("fast_mode1_multi", 16'(fast), 16'h0000);
        seed = lfsr(seed);
        k = 8 + int'(seed[4:0]);
        wr(3'h2, 16'(k));
        wr(3'h2, 16'h0007);
        rd(3'h2, 16'(k), "hold_wr");
        point_to_point_topology <= 1'b1;
        ack_en <= 1'b1;
        go_online();
        len(0, n);
        near("fast_mode1_len", n, (4 + k) * 4, 12);
        wr(3'h1, 16'h0064);
        wr(3'h0, 16'h0002);
        go_online();
        rd(3'h6, 16'h0003, "status_rd");
        len(0, n);
        near("fast_mode2_len", n, 100 * CPM - 10, 16);
        is_master <= 1'b0;
        go_online();
        chk("fast_remote", 16'(fast), 16'h0000);
        $display("sync modes done");
        seed = lfsr(seed);
        k = 1 + int'(seed[3:0]);
        wr(3'h3, 16'(k));
        @(posedge clk);
        sleep_exp <= 1'b1;
        @(posedge clk);
        sleep_exp <= 1'b0;
        @(negedge clk);
        chk("sniffing", 16'(sniff), 16'h0001);
        len(1, n);
        near("sniff_len", n, k * 8 - 10, 18);
        @(negedge clk);
        chk("sleep_pulse", 16'(go_sleep), 16'h0000);
        found <= 1'b1;
        @(posedge clk);
        sleep_exp <= 1'b1;
        @(posedge clk);
        sleep_exp <= 1'b0;
        n = 0;
        repeat (8 * k + 16) @(negedge clk) n += int'(go_sleep | sniff);
        chk("found_sniff", 16'(n), 16'h0000);
        found <= 1'b0;
        k = 2 + int'(seed[6:4]);
        wr(3'h5, 16'(k));
        sync_en <= 1'b1;
        repeat (40) @(negedge clk);
        chk("synced", 16'(synced), 16'h0001);
        sync_en <= 1'b0;
        len(2, n);
        near("loss_len", n, k * 8 - 10, 18);
        chk("searching", 16'(searching), 16'h0001);
        $display("sniff and loss done");
        is_master <= 1'b1;
        req <= 4'b0110;
        repeat (3) @(negedge clk);
        chk("grant_low", 16'(grant), 16'h0002);
        @(posedge clk);
        rel <= 4'b0010;
        req <= 4'b0100;
        @(posedge clk);
        rel <= 4'b0000;
        @(negedge clk);
        chk("grant_free", 16'(grant), 16'h0000);
        @(negedge clk);
        chk("grant_next", 16'(grant), 16'h0004);
        @(posedge clk);
        rel <= 4'b1111;
        @(posedge clk);
        rel <= 4'b0000;
        wr(3'h4, 16'h0000);
        req <= 4'b1111;
        repeat (4) @(negedge clk);
        chk("grant_off", 16'(grant), 16'h0000);
        wr(3'h4, 16'h0001);
        wr(3'h4, 16'h0002);
        rd(3'h4, 16'h0001, "chreq_wr");
        tdma <= 1'b1;
        repeat (4) @(negedge clk);
        chk("grant_tdma", 16'(grant), 16'h0000);
        s0 = slot;
        chk("slot_onehot", 16'($onehot(s0)), 16'h0001);
        repeat (12) @(negedge clk);
        chk("slot_moves", 16'(slot !== s0), 16'h0001);
        $display("channel access done");
        wrap_up();
    end
endmodule
`default_nettype wire
